// File: core/port_power_strap_mode_ctrl.sv
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Dedicated power output drives high for port power on, low for off.
// - Combined pin is open drain, enabling power and sensing over-current.
// - Latched charge strap 1 enables charging on its port, 0 disables.
// - Straps captured at power-on reset and each chip reset rise, then held.
// - Chip reset low means standby: ports undriven, only reset input and register reads watched.
// - Chip reset high means hub mode with charger detection enabled.
// - Regulator enable follows chip reset high, off in standby.
// - Configuration may take swap select from the port b pin instead.
// - Swap select 0 keeps port 0 upstream; 1 makes port 1 upstream.
// - Standby discards configuration; defaults are restored before operating.
module port_power_strap_mode_ctrl (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic chip_reset_low,
   input wire logic swap_select_pin,
   input wire logic port_b_overcurrent_low,
   input wire logic port_c_overcurrent_low,
   input wire logic port_d_overcurrent_low,
   input wire logic port_b_combined_pin_in,
   input wire logic port_c_combined_pin_in,
   input wire logic port_d_combined_pin_in,
   output logic port_b_combined_pin_out,
   output logic port_c_combined_pin_out,
   output logic port_d_combined_pin_out,
   output logic port_b_combined_pin_oe_n,
   output logic port_c_combined_pin_oe_n,
   output logic port_d_combined_pin_oe_n,
   output logic port_b_charge_enable,
   output logic port_c_charge_enable,
   output logic port_d_charge_enable,
   output logic hub_mode,
   output logic charger_detect_enable,
   output logic regulator_enable,
   output logic upstream_is_port1,
   input wire logic [port_power_pkg::ADDR_WIDTH-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [port_power_pkg::DATA_WIDTH-1:0] avs_writedata,
   output logic [port_power_pkg::DATA_WIDTH-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import port_power_pkg::*;

   logic rst_meta_q;
   logic rst_n;

   logic chip_run;
   logic swap_pin_level;
   logic [NUM_PORTS-1:0] oc_pin_level;
   logic [NUM_PORTS-1:0] pin_level;

   mode_type mode_q;
   mode_type mode_d;
   logic [SETTLE_CNT_WIDTH-1:0] settle_cnt_q;
   logic [SETTLE_CNT_WIDTH-1:0] settle_cnt_d;
   logic capture;

   logic [CTRL_WIDTH-1:0] ctrl_q;
   logic [CTRL_WIDTH-1:0] ctrl_d;
   logic [NUM_PORTS-1:0] fault_q;
   logic [NUM_PORTS-1:0] fault_d;

   logic waitreq_q;
   logic waitreq_d;
   logic [DATA_WIDTH-1:0] rdata_q;
   logic [DATA_WIDTH-1:0] rdata_d;
   logic bus_req;
   logic bus_take;

   logic [NUM_PORTS-1:0] charge_q;
   logic [NUM_PORTS-1:0] charge_d;
   logic hub_q;
   logic hub_d;
   logic reg_en_q;
   logic reg_en_d;
   logic up1_q;
   logic up1_d;
   logic swap_value;

   logic [NUM_PORTS-1:0] pin_out;
   logic [NUM_PORTS-1:0] pin_oe_n;

   port_ctrl_if pif ();

   // Reset release is synchronised; assertion stays asynchronous.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // The chip reset pin idles low so that the block starts in standby.
   input_sync #(
      .WIDTH(2),
      .RESET_VALUE(2'h0)
   ) u_sync_ctrl (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({swap_select_pin, chip_reset_low}),
      .level_out({swap_pin_level, chip_run})
   );

   // Sense inputs have pull-ups, so they rest at the no-fault level.
   input_sync #(
      .WIDTH(NUM_PORTS),
      .RESET_VALUE(OC_PIN_RESET)
   ) u_sync_oc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({port_d_overcurrent_low, port_c_overcurrent_low, port_b_overcurrent_low}),
      .level_out(oc_pin_level)
   );

   input_sync #(
      .WIDTH(NUM_PORTS),
      .RESET_VALUE(OC_PIN_RESET)
   ) u_sync_pin (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({port_d_combined_pin_in, port_c_combined_pin_in, port_b_combined_pin_in}),
      .level_out(pin_level)
   );

   // Mode sequencing: power-on capture, standby, strap settle, hub.
   always_comb begin
      mode_d = mode_q;
      settle_cnt_d = settle_cnt_q;
      capture = 1'b0;
      case (mode_q)
         MODE_POR_CAPTURE: begin
            // The pin levels need the synchroniser's latency before they are taken.
            if (settle_cnt_q == SETTLE_CNT_WIDTH'(STRAP_SETTLE_CYCLES - 1)) begin
               capture = 1'b1;
               mode_d = MODE_STANDBY;
            end else begin
               settle_cnt_d = settle_cnt_q + 1'b1;
            end
         end
         MODE_STANDBY: begin
            settle_cnt_d = '0;
            if (chip_run) begin
               mode_d = MODE_SETTLE;
            end
         end
         MODE_SETTLE: begin
            if (!chip_run) begin
               mode_d = MODE_STANDBY;
            end else if (settle_cnt_q == SETTLE_CNT_WIDTH'(STRAP_SETTLE_CYCLES - 1)) begin
               // Straps are taken after the settle time, before pins are driven.
               capture = 1'b1;
               mode_d = MODE_HUB;
            end else begin
               settle_cnt_d = settle_cnt_q + 1'b1;
            end
         end
         MODE_HUB: begin
            if (!chip_run) begin
               mode_d = MODE_STANDBY;
            end
         end
         default: begin
            mode_d = MODE_STANDBY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_POR_CAPTURE;
         settle_cnt_q <= '0;
      end else begin
         mode_q <= mode_d;
         settle_cnt_q <= settle_cnt_d;
      end
   end

   // Register slave: one wait cycle, then a single-cycle answer.
   assign bus_req = avs_read || avs_write;
   assign bus_take = bus_req && !waitreq_q;

   always_comb begin
      waitreq_d = !(bus_req && waitreq_q);
      rdata_d = '0;
      if (bus_req && waitreq_q && avs_read) begin
         case (avs_address)
            CTRL_OFFSET: begin
               rdata_d[CTRL_WIDTH-1:0] = ctrl_q;
            end
            STATUS_OFFSET: begin
               rdata_d[STAT_STRAP_LSB +: NUM_PORTS] = pif.strap;
               rdata_d[STAT_OC_LSB +: NUM_PORTS] = pif.overcurrent;
               rdata_d[STAT_HUB_BIT] = hub_q;
               rdata_d[STAT_UP1_BIT] = up1_q;
               rdata_d[STAT_REG_BIT] = reg_en_q;
            end
            FAULT_OFFSET: begin
               rdata_d[FAULT_LSB +: NUM_PORTS] = fault_q;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end else if (!waitreq_q) begin
         rdata_d = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         waitreq_q <= 1'b1;
         rdata_q <= '0;
      end else begin
         waitreq_q <= waitreq_d;
         rdata_q <= rdata_d;
      end
   end

   // Configuration lives only in hub mode; standby wipes it back to defaults.
   always_comb begin
      ctrl_d = ctrl_q;
      fault_d = fault_q;
      if (mode_q != MODE_HUB) begin
         ctrl_d = CTRL_RESET;
         fault_d = FAULT_RESET;
      end else begin
         if (bus_take && avs_write && avs_address == CTRL_OFFSET) begin
            ctrl_d = avs_writedata[CTRL_WIDTH-1:0];
         end
         if (bus_take && avs_write && avs_address == FAULT_OFFSET) begin
            fault_d = fault_q & ~avs_writedata[FAULT_LSB +: NUM_PORTS];
         end
         // A fault arriving with its clear is kept.
         fault_d = fault_d | pif.overcurrent;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
         fault_q <= FAULT_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         fault_q <= fault_d;
      end
   end

   // A latched fault holds the port off until software clears it.
   assign pif.pin_level = pin_level;
   assign pif.oc_pin_level = oc_pin_level;
   assign pif.power_req = ctrl_q[CTRL_POWER_LSB +: NUM_PORTS] & ~fault_q;
   assign pif.combined_sel = ctrl_q[CTRL_COMBINED_LSB +: NUM_PORTS];
   assign pif.swap_alt = ctrl_q[CTRL_SWAP_ALT_BIT];
   assign pif.drive_en = (mode_q == MODE_HUB);
   assign pif.capture = capture;

   port_pins u_pins (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ctl(pif.port),
      .pin_out(pin_out),
      .pin_oe_n(pin_oe_n)
   );

   // Swap select source is the dedicated pin or, when configured, port b.
   assign swap_value = pif.swap_alt ? pin_level[0] : swap_pin_level;

   always_comb begin
      // Taken from the present mode so that the new straps are out with hub mode.
      hub_d = (mode_q == MODE_HUB);
      reg_en_d = chip_run;
      charge_d = (mode_q == MODE_HUB) ? pif.strap : '0;
      up1_d = (mode_q == MODE_HUB) && swap_value;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hub_q <= 1'b0;
         reg_en_q <= 1'b0;
         charge_q <= '0;
         up1_q <= 1'b0;
      end else begin
         hub_q <= hub_d;
         reg_en_q <= reg_en_d;
         charge_q <= charge_d;
         up1_q <= up1_d;
      end
   end

   assign port_b_combined_pin_out = pin_out[0];
   assign port_c_combined_pin_out = pin_out[1];
   assign port_d_combined_pin_out = pin_out[2];
   assign port_b_combined_pin_oe_n = pin_oe_n[0];
   assign port_c_combined_pin_oe_n = pin_oe_n[1];
   assign port_d_combined_pin_oe_n = pin_oe_n[2];
   assign port_b_charge_enable = charge_q[0];
   assign port_c_charge_enable = charge_q[1];
   assign port_d_charge_enable = charge_q[2];
   assign hub_mode = hub_q;
   assign charger_detect_enable = hub_q;
   assign regulator_enable = reg_en_q;
   assign upstream_is_port1 = up1_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = waitreq_q;

endmodule : port_power_strap_mode_ctrl

// File: pkg/port_power_pkg.sv
package port_power_pkg;

   localparam int NUM_PORTS = 3;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 32;

   // Register byte offsets.
   localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 4'h4;
   localparam logic [ADDR_WIDTH-1:0] FAULT_OFFSET = 4'h8;

   // Control register fields.
   localparam int CTRL_POWER_LSB = 0;
   localparam int CTRL_COMBINED_LSB = 3;
   localparam int CTRL_SWAP_ALT_BIT = 6;
   localparam int CTRL_WIDTH = 7;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;

   // Status register fields.
   localparam int STAT_STRAP_LSB = 0;
   localparam int STAT_OC_LSB = 3;
   localparam int STAT_HUB_BIT = 6;
   localparam int STAT_UP1_BIT = 7;
   localparam int STAT_REG_BIT = 8;

   // Fault register fields and reset values.
   localparam int FAULT_LSB = 0;
   localparam logic [NUM_PORTS-1:0] FAULT_RESET = 3'h0;
   localparam logic [NUM_PORTS-1:0] STRAP_RESET = 3'h0;
   localparam logic [NUM_PORTS-1:0] OC_PIN_RESET = 3'h7;

   // Strap settling time before capture after the chip reset rises.
   localparam int CLK_PERIOD_NS = 40;
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CNT_WIDTH = 5;

   // Edges a released combined pin is not sensed, covering the synchroniser lag.
   localparam int RELEASE_BLANK_CYCLES = 4;

   typedef enum logic [1:0] {
      MODE_POR_CAPTURE = 2'b00,
      MODE_STANDBY = 2'b01,
      MODE_SETTLE = 2'b10,
      MODE_HUB = 2'b11
   } mode_type;

endpackage : port_power_pkg

// File: pkg/port_ctrl_if.sv
`timescale 1ns/1ps
interface port_ctrl_if;
   import port_power_pkg::*;
   logic [NUM_PORTS-1:0] pin_level;
   logic [NUM_PORTS-1:0] oc_pin_level;
   logic [NUM_PORTS-1:0] power_req;
   logic [NUM_PORTS-1:0] combined_sel;
   logic [NUM_PORTS-1:0] strap;
   logic [NUM_PORTS-1:0] overcurrent;
   logic drive_en;
   logic capture;
   logic swap_alt;

   modport ctrl (
      output pin_level,
      output oc_pin_level,
      output power_req,
      output combined_sel,
      output drive_en,
      output capture,
      output swap_alt,
      input strap,
      input overcurrent
   );

   modport port (
      input pin_level,
      input oc_pin_level,
      input power_req,
      input combined_sel,
      input drive_en,
      input capture,
      input swap_alt,
      output strap,
      output overcurrent
   );
endinterface : port_ctrl_if

// File: core/input_sync.sv
`timescale 1ns/1ps
module input_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;

   // A change is accepted only once the second and third stages agree.
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         level_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : level_q[i];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RESET_VALUE;
         stage2_q <= RESET_VALUE;
         stage3_q <= RESET_VALUE;
         level_q <= RESET_VALUE;
      end else begin
         meta_q <= async_in;
         stage2_q <= meta_q;
         stage3_q <= stage2_q;
         level_q <= level_d;
      end
   end

   assign level_out = level_q;
endmodule : input_sync

// File: core/port_pins.sv
`timescale 1ns/1ps
module port_pins (
   input wire logic sys_clk,
   input wire logic rst_n,
   port_ctrl_if.port ctl,
   output logic [port_power_pkg::NUM_PORTS-1:0] pin_out,
   output logic [port_power_pkg::NUM_PORTS-1:0] pin_oe_n
);
   import port_power_pkg::*;

   logic [NUM_PORTS-1:0] strap_q;
   logic [NUM_PORTS-1:0] strap_d;
   logic [NUM_PORTS-1:0] oc_q;
   logic [NUM_PORTS-1:0] oc_d;
   logic [NUM_PORTS-1:0] out_q;
   logic [NUM_PORTS-1:0] out_d;
   logic [NUM_PORTS-1:0] oe_n_q;
   logic [NUM_PORTS-1:0] oe_n_d;
   logic [2:0] rel_cnt_q [NUM_PORTS];
   logic [2:0] rel_cnt_d [NUM_PORTS];

   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      always_comb begin
         strap_d[i] = ctl.capture ? ctl.pin_level[i] : strap_q[i];
         // A freshly released pin still reads low through the synchroniser.
         // Sensing it then would latch a false fault, so it is blanked.
         rel_cnt_d[i] = rel_cnt_q[i];
         if (!oe_n_q[i]) begin
            rel_cnt_d[i] = 3'h0;
         end else if (rel_cnt_q[i] != 3'(RELEASE_BLANK_CYCLES)) begin
            rel_cnt_d[i] = rel_cnt_q[i] + 3'h1;
         end
         out_d[i] = 1'b0;
         oe_n_d[i] = 1'b1;
         oc_d[i] = 1'b0;
         if (!ctl.drive_en || (i == 0 && ctl.swap_alt)) begin
            // Undriven while straps settle, in standby, or when the pin feeds swap select.
            out_d[i] = 1'b0;
            oe_n_d[i] = 1'b1;
         end else if (ctl.combined_sel[i]) begin
            // Open drain: pull low for off, release for on and sense the fault.
            out_d[i] = 1'b0;
            oe_n_d[i] = ctl.power_req[i];
            oc_d[i] = oe_n_q[i] && (rel_cnt_q[i] == 3'(RELEASE_BLANK_CYCLES)) &&
               !ctl.pin_level[i];
         end else begin
            out_d[i] = ctl.power_req[i];
            oe_n_d[i] = 1'b0;
            oc_d[i] = !ctl.oc_pin_level[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_q <= STRAP_RESET;
         oc_q <= '0;
         out_q <= '0;
         oe_n_q <= '1;
         rel_cnt_q <= '{default: 3'h0};
      end else begin
         strap_q <= strap_d;
         oc_q <= oc_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         rel_cnt_q <= rel_cnt_d;
      end
   end

   assign ctl.strap = strap_q;
   assign ctl.overcurrent = oc_q;
   assign pin_out = out_q;
   assign pin_oe_n = oe_n_q;
endmodule : port_pins

// File: tb/port_power_far_side.sv
`timescale 1ns/1ps
module port_power_far_side
   import port_power_pkg::*;
(
   input wire logic [NUM_PORTS-1:0] pin_out,
   input wire logic [NUM_PORTS-1:0] pin_oe_n,
   input wire logic [NUM_PORTS-1:0] strap,
   input wire logic show_strap,
   input wire logic [NUM_PORTS-1:0] oc_fault,
   input wire logic [NUM_PORTS-1:0] pin_fault,
   output logic [NUM_PORTS-1:0] oc_low,
   output logic [NUM_PORTS-1:0] pin_level
);
   assign oc_low = ~oc_fault;
   // A released pin shows its strap resistor or the pull-up, and a tripped monitor sinks it.
   assign pin_level = (~pin_oe_n & pin_out) |
      (pin_oe_n & ~pin_fault & (show_strap ? strap : '1));
endmodule : port_power_far_side

// File: tb/port_power_monitor.sv
`timescale 1ns/1ps
module port_power_monitor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic chip_reset_low,
   input wire logic port_b_combined_pin_oe_n,
   input wire logic port_c_combined_pin_oe_n,
   input wire logic port_d_combined_pin_oe_n,
   input wire logic port_b_charge_enable,
   input wire logic port_c_charge_enable,
   input wire logic port_d_charge_enable,
   input wire logic hub_mode,
   input wire logic charger_detect_enable,
   input wire logic regulator_enable,
   input wire logic upstream_is_port1
);
   logic [2:0] oe_n;
   logic [2:0] chg;
   assign oe_n = {port_d_combined_pin_oe_n, port_c_combined_pin_oe_n, port_b_combined_pin_oe_n};
   assign chg = {port_d_charge_enable, port_c_charge_enable, port_b_charge_enable};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Eight cycles cover the four-flop synchroniser and the output register.
   sequence low_held;
      !chip_reset_low [*8];
   endsequence
   sequence high_held;
      chip_reset_low [*8];
   endsequence
   a_standby_released: assert property (low_held |-> &oe_n)
      else $error("pins driven in standby");
   a_standby_reg_off: assert property (low_held |-> !regulator_enable && !hub_mode)
      else $error("regulator on in standby");
   a_regulator_on: assert property (high_held |-> regulator_enable)
      else $error("regulator off with chip reset high");
   a_hub_charger: assert property (hub_mode == charger_detect_enable)
      else $error("charger detect differs from hub mode");
   a_hub_settle: assert property ($rose(hub_mode) |-> $past(chip_reset_low, 25))
      else $error("hub mode before straps settled");
   a_straps_held: assert property (hub_mode && $past(hub_mode) |-> $stable(chg))
      else $error("captured strap changed");
   a_pins_wait: assert property (!hub_mode && !$past(hub_mode) && !$past(hub_mode, 2) |-> &oe_n)
      else $error("pin driven before capture");
   a_charge_hub: assert property (!hub_mode |-> chg == 3'h0)
      else $error("charge enabled outside hub mode");
   a_swap_hub: assert property (!hub_mode |-> !upstream_is_port1)
      else $error("upstream swapped outside hub mode");
endmodule : port_power_monitor
bind port_power_strap_mode_ctrl port_power_monitor u_monitor (.sys_clk, .resetn,
   .chip_reset_low, .port_b_combined_pin_oe_n, .port_c_combined_pin_oe_n,
   .port_d_combined_pin_oe_n, .port_b_charge_enable, .port_c_charge_enable,
   .port_d_charge_enable, .hub_mode, .charger_detect_enable, .regulator_enable,
   .upstream_is_port1);

// File: tb/test_port_power_strap_mode_ctrl.sv
`timescale 1ns/1ps
module test_port_power_strap_mode_ctrl;
   import port_power_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic chip_reset_low = 1'b0;
   logic swap_select_pin = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] pin_out, pin_oe_n, pin_level, oc_low, chg;
   logic [2:0] strap = 3'h3;
   logic show_strap = 1'b1;
   logic [2:0] oc_fault = 3'h0;
   logic [2:0] pin_fault = 3'h0;
   logic hub_mode, charger_detect_enable, regulator_enable, upstream_is_port1;
   logic [31:0] rd;
   int errors = 0;
   int num_checks = 0;
   always #20 sys_clk = ~sys_clk;
   port_power_strap_mode_ctrl u_dut (.sys_clk, .resetn, .chip_reset_low, .swap_select_pin,
      .port_b_overcurrent_low(oc_low[0]), .port_c_overcurrent_low(oc_low[1]),
      .port_d_overcurrent_low(oc_low[2]), .port_b_combined_pin_in(pin_level[0]),
      .port_c_combined_pin_in(pin_level[1]), .port_d_combined_pin_in(pin_level[2]),
      .port_b_combined_pin_out(pin_out[0]), .port_c_combined_pin_out(pin_out[1]),
      .port_d_combined_pin_out(pin_out[2]), .port_b_combined_pin_oe_n(pin_oe_n[0]),
      .port_c_combined_pin_oe_n(pin_oe_n[1]), .port_d_combined_pin_oe_n(pin_oe_n[2]),
      .port_b_charge_enable(chg[0]), .port_c_charge_enable(chg[1]),
      .port_d_charge_enable(chg[2]), .hub_mode, .charger_detect_enable, .regulator_enable,
      .upstream_is_port1, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest);
   port_power_far_side u_far (.pin_out, .pin_oe_n, .strap, .show_strap, .oc_fault,
      .pin_fault, .oc_low, .pin_level);
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cycles
   // The request is held until waitrequest is seen low, then an idle cycle follows.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) errors++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic test_standby();
      cycles(30);
      check(hub_mode, 1'b0);
      check(regulator_enable, 1'b0);
      check(pin_oe_n, 3'h7);
      bus(1'b1, CTRL_OFFSET, 32'h7f);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      check(rd, 32'h3);
      $display("test_standby done");
   endtask : test_standby
   task automatic test_capture(input logic [2:0] s);
      int n;
      n = 0;
      strap <= s;
      show_strap <= 1'b1;
      chip_reset_low <= 1'b1;
      while (hub_mode !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      check(hub_mode, 1'b1);
      check(n > STRAP_SETTLE_CYCLES, 1'b1);
      check(chg, s);
      check(charger_detect_enable, 1'b1);
      check(regulator_enable, 1'b1);
      cycles(2);
      show_strap <= 1'b0;
      strap <= ~s;
      cycles(6);
      check(chg, s);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      check(rd, (32'h1 << STAT_REG_BIT) | (32'h1 << STAT_HUB_BIT) | s);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      check(rd, 32'h0);
      $display("test_capture done");
   endtask : test_capture
   task automatic test_power();
      bus(1'b0, 4'hc, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, CTRL_OFFSET, 32'h7);
      cycles(3);
      check(pin_oe_n, 3'h0);
      check(pin_out, 3'h7);
      oc_fault <= 3'h2;
      cycles(10);
      check(pin_out, 3'h5);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      check(rd[5:3], 3'h2);
      oc_fault <= 3'h0;
      cycles(8);
      bus(1'b1, FAULT_OFFSET, 32'h7);
      cycles(3);
      check(pin_out, 3'h7);
      bus(1'b1, CTRL_OFFSET, 32'h0);
      cycles(3);
      check(pin_out, 3'h0);
      $display("test_power done");
   endtask : test_power
   task automatic test_combined();
      bus(1'b1, CTRL_OFFSET, 32'h39);
      cycles(3);
      check(pin_oe_n, 3'h1);
      check(pin_out, 3'h0);
      pin_fault <= 3'h1;
      cycles(10);
      check(pin_oe_n, 3'h0);
      bus(1'b0, FAULT_OFFSET, 32'h0);
      check(rd[2:0], 3'h1);
      pin_fault <= 3'h0;
      cycles(8);
      bus(1'b1, FAULT_OFFSET, 32'h1);
      cycles(8);
      check(pin_oe_n, 3'h1);
      $display("test_combined done");
   endtask : test_combined
   task automatic test_swap();
      bus(1'b1, CTRL_OFFSET, 32'h0);
      swap_select_pin <= 1'b1;
      cycles(8);
      check(upstream_is_port1, 1'b1);
      swap_select_pin <= 1'b0;
      cycles(8);
      check(upstream_is_port1, 1'b0);
      bus(1'b1, CTRL_OFFSET, 32'h40);
      cycles(8);
      check(pin_oe_n[0], 1'b1);
      check(upstream_is_port1, 1'b1);
      pin_fault <= 3'h1;
      cycles(8);
      check(upstream_is_port1, 1'b0);
      pin_fault <= 3'h0;
      $display("test_swap done");
   endtask : test_swap
   task automatic test_reentry();
      chip_reset_low <= 1'b0;
      cycles(8);
      check(hub_mode, 1'b0);
      check(chg, 3'h0);
      check(pin_oe_n, 3'h7);
      check(regulator_enable, 1'b0);
      test_capture(3'h2);
      $display("test_reentry done");
   endtask : test_reentry
   initial begin
      cycles(4);
      resetn <= 1'b1;
      cycles(4);
      test_standby();
      test_capture(3'h5);
      test_power();
      test_combined();
      test_swap();
      test_reentry();
      end_of_test();
   end
   // The whole sequence needs well under two thousand cycles.
   initial begin
      cycles(20000);
      errors++;
      end_of_test();
   end
endmodule : test_port_power_strap_mode_ctrl
